//--- design/prn_node.sv
// polled network node: master probe/poll engine, slave responder, host fifo
//*****************************************************************
// host output fifo
//*****************************************************************
module prn_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 16
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // honest flags straight from the fill count
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage, no reset needed on data
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : prn_fifo

//*****************************************************************
// node top
//*****************************************************************
module prn_node
   import prn_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [4:0]  station_addr,
   input  wire logic [4:0]  last_slave_addr,
   input  wire logic        host_cfg_valid,
   output logic             host_cfg_ready,
   input  wire logic [4:0]  host_cfg_addr,
   input  wire logic [7:0]  host_cfg_data,
   output logic             host_out_valid,
   input  wire logic        host_out_ready,
   output logic [7:0]       host_out_data,
   output logic             net_tx_valid,
   input  wire logic        net_tx_ready,
   output logic [1:0]       net_tx_kind,
   output logic [4:0]       net_tx_addr,
   output logic [7:0]       net_tx_data,
   output logic             net_tx_last,
   input  wire logic        net_rx_valid,
   output logic             net_rx_ready,
   input  wire logic [1:0]  net_rx_kind,
   input  wire logic [4:0]  net_rx_addr,
   input  wire logic [7:0]  net_rx_data,
   input  wire logic        net_rx_last,
   input  wire logic        local_valid,
   output logic             local_ready,
   input  wire logic [7:0]  local_data,
   input  wire logic        local_last,
   output logic             slave_cfg_valid,
   output logic [7:0]       slave_cfg_data,
   output logic             init_done
);
   localparam int unsigned TW = $clog2(RSP_TIMEOUT_CYC + 1);

   // ascii digit of a value below ten
   function automatic logic [7:0] digit(input logic [4:0] v);
      digit = CHAR_ZERO + {3'h0, v};
   endfunction : digit

   prn_state_t  st_q;
   logic        is_slave;
   logic        init_q;
   logic [4:0]  addr_q;
   logic [4:0]  last_eff;
   logic [31:0] alive_q;
   logic [TW-1:0] tmo_q;
   logic [1:0]  rep_idx_q;
   logic [7:0]  rep_char_q;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [7:0]  fifo_in_data;
   logic        tx_free;
   logic        rsp_beat;
   logic        for_me;
   logic        slave_busy_q;
   logic        slave_probe_q;
   logic [4:0]  next_alive;
   logic        any_alive;

   assign is_slave = (station_addr != MASTER_ADDR);
   // clamp the bound to the largest legal address
   assign last_eff = (last_slave_addr > MAX_SLAVE_ADDR) ? MAX_SLAVE_ADDR : last_slave_addr;
   assign tx_free  = !net_tx_valid || net_tx_ready;
   assign rsp_beat = net_rx_valid && net_rx_ready;
   assign for_me   = net_rx_valid && (net_rx_addr == station_addr) && (net_rx_kind != KIND_DATA);

   // round-robin search for the next slave still alive after addr_q
   always_comb
   begin
      next_alive = addr_q;
      any_alive  = 1'b0;
      for (int i = 1; i <= 31; i++)
      begin
         logic [4:0] a;
         a = 5'(addr_q + 5'(i));
         if (!any_alive && a != MASTER_ADDR && a <= last_eff && alive_q[a])
         begin
            next_alive = a;
            any_alive  = 1'b1;
         end
      end
   end

   // fifo feed: reports in init and on every timeout, reply bytes after init; full fifo stalls the reply
   always_comb
   begin
      fifo_in_valid = 1'b0;
      fifo_in_data  = rep_char_q;
      net_rx_ready  = 1'b0;
      if (!is_slave && st_q == ST_REPORT)
      begin
         fifo_in_valid = 1'b1;
      end
      else if (!is_slave && (st_q == ST_WAIT || st_q == ST_RECV))
      begin
         net_rx_ready  = !init_q || fifo_in_ready;
         fifo_in_valid = net_rx_valid && init_q && net_rx_kind == KIND_DATA && net_rx_addr == addr_q;
         fifo_in_data  = net_rx_data;
      end
      else if (is_slave)
      begin
         net_rx_ready = !slave_busy_q; // prompts ignored while answering
      end
   end

   prn_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (host_out_valid),
      .out_ready (host_out_ready),
      .out_data  (host_out_data)
   );

   assign host_cfg_ready = !is_slave && init_q && st_q == ST_IDLE && tx_free;
   assign local_ready    = is_slave && slave_busy_q && !slave_probe_q && tx_free;

   // master sequencer: probe pass, then polling with relayed configuration
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_q       <= ST_SEND;
         init_q     <= 1'b0;
         addr_q     <= 5'h01;
         alive_q    <= '1;
         tmo_q      <= '0;
         rep_idx_q  <= '0;
         rep_char_q <= '0;
      end
      else if (!is_slave)
      begin
         unique case (st_q)
            ST_IDLE:
            begin
               if (host_cfg_valid && host_cfg_ready)
               begin
                  addr_q <= host_cfg_addr;
                  st_q   <= ST_WAIT;
                  tmo_q  <= TW'(RSP_TIMEOUT_CYC);
               end
               else if (any_alive && tx_free)
               begin
                  addr_q <= next_alive;
                  st_q   <= ST_SEND;
               end
            end
            ST_SEND:
            begin
               if (!init_q && (addr_q > last_eff || addr_q == MASTER_ADDR))
               begin
                  init_q <= 1'b1; // probe pass over
                  st_q   <= ST_IDLE;
               end
               else if (tx_free)
               begin
                  st_q  <= ST_WAIT;
                  tmo_q <= TW'(RSP_TIMEOUT_CYC);
               end
            end
            ST_WAIT:
            begin
               if (rsp_beat && net_rx_addr == addr_q && net_rx_kind == KIND_DATA)
               begin
                  st_q <= net_rx_last ? (init_q ? ST_IDLE : ST_REPORT) : ST_RECV;
                  rep_char_q <= digit(5'(addr_q / 5'd10));
                  rep_idx_q  <= '0;
               end
               else if (net_rx_valid && net_rx_addr == addr_q && net_rx_kind == KIND_DATA)
               begin
                  tmo_q <= tmo_q; // reply has begun, only a full fifo holds it back
               end
               else if (tmo_q == '0)
               begin
                  alive_q[addr_q] <= 1'b0;
                  rep_char_q <= digit(5'(addr_q / 5'd10));
                  rep_idx_q  <= '0;
                  st_q       <= ST_REPORT;
               end
               else
               begin
                  tmo_q <= tmo_q - 1'b1;
               end
            end
            ST_RECV:
            begin
               // once a reply has started the timer no longer applies
               if (rsp_beat && net_rx_last)
               begin
                  st_q <= init_q ? ST_IDLE : ST_REPORT;
               end
            end
            ST_REPORT:
            begin
               if (fifo_in_ready)
               begin
                  rep_idx_q <= rep_idx_q + 1'b1;
                  unique case (rep_idx_q)
                     2'd0:    rep_char_q <= digit(5'(addr_q % 5'd10));
                     2'd1:    rep_char_q <= alive_q[addr_q] ? CHAR_START : CHAR_TIMEOUT;
                     default: rep_char_q <= rep_char_q;
                  endcase
                  if (rep_idx_q == 2'd2)
                  begin
                     st_q   <= init_q ? ST_IDLE : ST_SEND;
                     addr_q <= init_q ? addr_q : 5'(addr_q + 1'b1);
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // slave prompt tracking: answer only after a probe or poll for our address
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         slave_busy_q  <= 1'b0;
         slave_probe_q <= 1'b0;
      end
      else if (is_slave)
      begin
         if (!slave_busy_q && for_me && net_rx_kind != KIND_CONFIG)
         begin
            slave_busy_q  <= 1'b1;
            slave_probe_q <= (net_rx_kind == KIND_PROBE);
         end
         else if (slave_busy_q && tx_free && (slave_probe_q || (local_valid && local_last)))
         begin
            slave_busy_q  <= 1'b0;
            slave_probe_q <= 1'b0;
         end
      end
   end

   // slave configuration receive
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         slave_cfg_valid <= 1'b0;
         slave_cfg_data  <= '0;
      end
      else
      begin
         slave_cfg_valid <= is_slave && for_me && net_rx_ready && net_rx_kind == KIND_CONFIG;
         if (is_slave && for_me && net_rx_ready && net_rx_kind == KIND_CONFIG)
         begin
            slave_cfg_data <= net_rx_data;
         end
      end
   end

   // shared transmit register for both roles
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         net_tx_valid <= 1'b0;
         net_tx_kind  <= KIND_PROBE;
         net_tx_addr  <= '0;
         net_tx_data  <= '0;
         net_tx_last  <= 1'b0;
      end
      else if (tx_free)
      begin
         net_tx_valid <= 1'b0;
         if (is_slave && slave_busy_q && (slave_probe_q || local_valid))
         begin
            net_tx_valid <= 1'b1;
            net_tx_kind  <= KIND_DATA;
            net_tx_addr  <= station_addr;
            net_tx_data  <= slave_probe_q ? PROBE_ACK : local_data;
            net_tx_last  <= slave_probe_q || local_last;
         end
         else if (!is_slave && st_q == ST_SEND && !(!init_q && (addr_q > last_eff || addr_q == MASTER_ADDR)))
         begin
            net_tx_valid <= 1'b1;
            net_tx_kind  <= init_q ? KIND_POLL : KIND_PROBE;
            net_tx_addr  <= addr_q;
            net_tx_data  <= '0;
            net_tx_last  <= 1'b1;
         end
         else if (host_cfg_valid && host_cfg_ready)
         begin
            net_tx_valid <= 1'b1;
            net_tx_kind  <= KIND_CONFIG;
            net_tx_addr  <= host_cfg_addr;
            net_tx_data  <= host_cfg_data;
            net_tx_last  <= 1'b1;
         end
      end
   end

   assign init_done = init_q;
endmodule : prn_node

//--- design/prn_pkg.sv
// constants for the polled reader network node
//*****************************************************************
//*****************************************************************
package prn_pkg;
   localparam int unsigned   CLK_PERIOD_NS  = 4;
   localparam int unsigned   RSP_TIMEOUT_NS = 2000;
   localparam int unsigned   RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [4:0]    MASTER_ADDR    = 5'h00;
   localparam logic [4:0]    MAX_SLAVE_ADDR = 5'h1F;
   localparam logic [1:0]    KIND_PROBE     = 2'h0;
   localparam logic [1:0]    KIND_POLL      = 2'h1;
   localparam logic [1:0]    KIND_CONFIG    = 2'h2;
   localparam logic [1:0]    KIND_DATA      = 2'h3;
   localparam logic [7:0]    CHAR_START     = 8'h53;
   localparam logic [7:0]    CHAR_TIMEOUT   = 8'h54;
   localparam logic [7:0]    CHAR_ZERO      = 8'h30;
   localparam logic [7:0]    PROBE_ACK      = 8'h06;
   localparam int unsigned   FIFO_DEPTH     = 16;
   localparam int unsigned   BYTE_W         = 8;
   typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV, ST_REPORT} prn_state_t;
endpackage : prn_pkg

//--- bench/prn_node_properties.sv
// port-level checks for the polled network node
//*****************************
// checker
//*****************************
module prn_node_properties
   import prn_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [4:0] station_addr,
   input wire logic [4:0] last_slave_addr,
   input wire logic       net_tx_valid,
   input wire logic       net_tx_ready,
   input wire logic [1:0] net_tx_kind,
   input wire logic [4:0] net_tx_addr,
   input wire logic       net_tx_last,
   input wire logic       net_rx_valid,
   input wire logic       net_rx_ready,
   input wire logic [1:0] net_rx_kind,
   input wire logic [4:0] net_rx_addr,
   input wire logic [7:0] net_rx_data,
   input wire logic       slave_cfg_valid,
   input wire logic [7:0] slave_cfg_data,
   input wire logic       local_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       pend_q;
   logic       prm_q;
   logic [4:0] adr_q;
   logic [9:0] wcnt_q;
   wire        mst = station_addr == MASTER_ADDR;
   wire        tk  = net_tx_valid && net_tx_ready;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // age of the open master request; the first reply beat ends the wait
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         {pend_q, wcnt_q, adr_q} <= {1'b0, 10'h000, 5'h00};
      else if (mst && tk)
         {pend_q, wcnt_q, adr_q} <= {1'b1, 10'h000, net_tx_addr};
      else if (net_rx_valid && net_rx_addr == adr_q)
         pend_q <= 1'b0;
      else if (pend_q)
         wcnt_q <= wcnt_q + 10'h001;
   // slave prompted and not yet finished answering
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         prm_q <= 1'b0;
      else if (net_rx_valid && net_rx_ready && net_rx_addr == station_addr && !net_rx_kind[1])
         prm_q <= 1'b1;
      else if (tk && net_tx_last)
         prm_q <= 1'b0;
   AST_ADDR_RANGE: assert property (mst && net_tx_valid |-> net_tx_addr != 5'h00 && net_tx_addr <= last_slave_addr)
      else $error("master addressed a station outside 1 to last");
   AST_FIRST_PROBE: assert property (mst && last_slave_addr != 5'h00 && $fell(reset) |-> ##[0:2] (tk && net_tx_addr == 5'h01))
      else $error("first probe after reset not aimed at station 1");
   AST_SLAVE_QUIET: assert property (!mst && net_tx_valid |-> net_tx_kind == KIND_DATA && net_tx_addr == station_addr)
      else $error("slave sent something other than its own data");
   AST_SLAVE_PROMPT: assert property (!mst && net_tx_valid |-> prm_q)
      else $error("slave transmitted without a prompt");
   AST_SLAVE_CFG: assert property (!mst && net_rx_valid && net_rx_ready && net_rx_kind == KIND_CONFIG && net_rx_addr == station_addr |=> slave_cfg_valid && slave_cfg_data == $past(net_rx_data))
      else $error("config byte not delivered");
   AST_LOCAL_PROMPT: assert property (!mst && local_ready |-> prm_q)
      else $error("slave offered to take local data without a prompt");
   AST_ONE_AT_A_TIME: assert property (mst && tk |=> !net_tx_valid [*8])
      else $error("master request overlapped an open one");
   AST_TMO_EARLY: assert property (mst && tk && pend_q |-> wcnt_q >= RSP_TIMEOUT_CYC - 4)
      else $error("unanswered request abandoned too early");
   AST_TMO_LATE: assert property (pend_q |-> wcnt_q <= RSP_TIMEOUT_CYC + 40)
      else $error("timeout not declared in time");
   C_PROBE_OK: cover property (mst && net_rx_valid && net_rx_ready && net_rx_data == PROBE_ACK);
   C_TIMEOUT: cover property (pend_q && wcnt_q == 10'h1F4);
   C_SLAVE_CFG: cover property (slave_cfg_valid);
endmodule : prn_node_properties

//--- bench/prn_slave_model.sv
// far-side model: a set of slave stations answering the master node
//*****************************
// slave stations
//*****************************
module prn_slave_model
   import prn_pkg::*;
#(
   parameter logic [31:0] ALIVE = 32'h0000000A,
   parameter int          DLY   = 20
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       net_tx_valid,
   output logic            net_tx_ready,
   input  wire logic [1:0] net_tx_kind,
   input  wire logic [4:0] net_tx_addr,
   input  wire logic [7:0] net_tx_data,
   output logic            net_rx_valid,
   input  wire logic       net_rx_ready,
   output logic [4:0]      net_rx_addr,
   output logic [7:0]      net_rx_data,
   output logic            net_rx_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rsp [2];
   int         n_q;
   int         idx_q;
   int         cnt_q;
   assign net_tx_ready = 1'b1;
   // answer a prompt to a present station DLY cycles after it is taken; released lines show inverted data
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         net_rx_valid <= 1'b0;
         net_rx_last  <= 1'b0;
         net_rx_addr  <= 5'h00;
         net_rx_data  <= 8'h00;
         cnt_q        <= 0;
      end
      else if (net_tx_valid && ALIVE[net_tx_addr])
      begin
         net_rx_addr <= net_tx_addr;
         cnt_q <= DLY;
         idx_q <= 0;
         rsp[0] <= net_tx_kind == KIND_PROBE ? PROBE_ACK : net_tx_kind == KIND_POLL ? 8'h40 + 8'(net_tx_addr) : net_tx_data;
         rsp[1] <= 8'h0A;
         n_q <= net_tx_kind == KIND_POLL ? 2 : 1;
      end
      else if (cnt_q > 1)
         cnt_q <= cnt_q - 1;
      else if (cnt_q == 1 && (!net_rx_valid || net_rx_ready))
      begin
         net_rx_valid <= idx_q < n_q;
         net_rx_data <= idx_q < n_q ? rsp[idx_q] : ~net_rx_data;
         net_rx_last <= idx_q == n_q - 1;
         idx_q <= idx_q + 1;
         cnt_q <= idx_q < n_q ? 1 : 0;
      end
   end
endmodule : prn_slave_model

//--- bench/prn_node_bench.sv
// self-checking bench for the polled network node
//*****************************
// bench top
//*****************************
module prn_node_bench;
   import prn_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, reset, own, host_cfg_valid, host_cfg_ready, host_out_valid, host_out_ready, b_v;
   logic        net_tx_valid, net_tx_ready, net_tx_last, net_rx_valid, net_rx_ready, net_rx_last, m_v, m_l;
   logic        local_valid, local_ready, local_last, slave_cfg_valid, init_done, full_seen;
   logic [1:0]  net_tx_kind, net_rx_kind, b_k;
   logic [4:0]  station_addr, last_slave_addr, host_cfg_addr, net_tx_addr, net_rx_addr, m_a, b_a;
   logic [7:0]  host_cfg_data, host_out_data, net_tx_data, net_rx_data, local_data, slave_cfg_data, m_d, b_d, cfg_d;
   logic [7:0]  hq[$];
   logic [14:0] tq[$];
   int          n_errors, checked;
   // the bench stands in for the master while the node is a slave
   assign net_rx_valid = own ? b_v : m_v;
   assign net_rx_kind  = own ? b_k : KIND_DATA;
   assign net_rx_addr  = own ? b_a : m_a;
   assign net_rx_data  = own ? b_d : m_d;
   assign net_rx_last  = own ? 1'b1 : m_l;
   prn_node dut (.*);
   prn_slave_model #(.ALIVE(32'h0000000A), .DLY(20)) u_far (.*, .net_rx_valid(m_v), .net_rx_addr(m_a),
      .net_rx_data(m_d), .net_rx_last(m_l));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // log beats taken at each edge, before that edge's updates land
   always @(posedge core_clk)
   begin
      if (host_out_valid && host_out_ready)
         hq.push_back(host_out_data);
      if (net_tx_valid && net_tx_ready)
         tq.push_back({net_tx_kind, net_tx_addr, net_tx_data});
      if (net_rx_valid && !net_rx_ready)
         full_seen = 1'b1;
      if (slave_cfg_valid)
         cfg_d = slave_cfg_data;
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic take(input logic [7:0] e);
      for (int t = 0; t < 3000 && hq.size() == 0; t++)
         @(negedge core_clk);
      chk("host_out_data", {8'h00, e}, {8'h00, hq.size() ? hq.pop_front() : 8'hXX});
   endtask : take
   task automatic report(input int a, input logic [7:0] c);
      take(8'(CHAR_ZERO + a / 10));
      take(8'(CHAR_ZERO + a % 10));
      take(c);
   endtask : report
   task automatic do_reset(input logic [4:0] st, input logic [4:0] last);
      {reset, own, station_addr, last_slave_addr} = {1'b1, st != MASTER_ADDR, st, last};
      repeat (8) @(negedge core_clk);
      hq.delete();
      tq.delete();
      reset = 1'b0;
   endtask : do_reset
   task automatic rx_beat(input logic [1:0] k, input logic [4:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {b_v, b_k, b_a, b_d} = {1'b1, k, a, d};
      #1;
      for (int t = 0; t < 100 && !net_rx_ready; t++)
         @(negedge core_clk);
      @(negedge core_clk);
      {b_v, b_d} = {1'b0, ~d};
   endtask : rx_beat
   task automatic test_init;
      do_reset(5'h00, 5'h03);
      report(1, CHAR_START);
      report(2, CHAR_TIMEOUT);
      report(3, CHAR_START);
      chk("first probe", {9'h000, KIND_PROBE, 5'h01}, {9'h000, tq[0][14:8]});
      repeat (4) @(negedge core_clk);
      chk("init_done", 16'h0001, {15'h0000, init_done});
   endtask : test_init
   task automatic test_poll;
      int hit;
      {full_seen, host_out_ready} = 2'b00;
      tq.delete();
      hq.delete();
      repeat (400) @(negedge core_clk);
      chk("net_rx_ready stall", 16'h0001, {15'h0000, full_seen});
      host_out_ready = 1'b1;
      take(8'h41);
      take(8'h0A);
      take(8'h43);
      hit = 0;
      foreach (tq[i])
         hit += tq[i][12:8] === 5'h02;
      chk("polls to timed-out station", 16'h0000, 16'(hit));
   endtask : test_poll
   task automatic test_cfg;
      int hit;
      tq.delete();
      @(negedge core_clk);
      {host_cfg_valid, host_cfg_addr, host_cfg_data} = {1'b1, 5'h03, 8'h5A};
      #1;
      for (int t = 0; t < 2000 && !host_cfg_ready; t++)
         @(negedge core_clk);
      @(negedge core_clk);
      host_cfg_valid = 1'b0;
      hq.delete();
      repeat (200) @(negedge core_clk);
      hit = 0;
      foreach (tq[i])
         hit += tq[i] === {KIND_CONFIG, 5'h03, 8'h5A};
      foreach (hq[i])
         hit += hq[i] === 8'h5A;
      chk("config relay", 16'h0002, 16'(hit));
   endtask : test_cfg
   task automatic test_slave;
      {local_valid, local_data, local_last} = {1'b1, 8'h77, 1'b1};
      do_reset(5'h05, 5'h00);
      repeat (50) @(negedge core_clk);
      chk("unprompted beats", 16'h0000, 16'(tq.size()));
      rx_beat(KIND_POLL, 5'h06, 8'h00);
      rx_beat(KIND_POLL, 5'h05, 8'h00);
      repeat (20) @(negedge core_clk);
      chk("poll answer", {1'b0, KIND_DATA, 5'h05, 8'h77}, {1'b0, tq[0]});
      rx_beat(KIND_PROBE, 5'h05, 8'h00);
      repeat (20) @(negedge core_clk);
      chk("probe answer", {1'b0, KIND_DATA, 5'h05, PROBE_ACK}, {1'b0, tq[1]});
      rx_beat(KIND_CONFIG, 5'h05, 8'h3C);
      repeat (4) @(negedge core_clk);
      chk("slave_cfg_data", 16'h003C, {8'h00, cfg_d});
   endtask : test_slave
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial
   begin
      {host_cfg_valid, b_v, local_valid, local_last, host_out_ready} = 5'h01;
      {host_cfg_addr, host_cfg_data, b_k, b_a, b_d, local_data} = {5'h00, 8'h00, 2'h0, 5'h00, 8'h00, 8'h00};
      test_init();
      test_poll();
      test_cfg();
      test_slave();
      give_verdict();
   end
   // a hang ends the run as a failure
   initial
   begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule : prn_node_bench
bind prn_node prn_node_properties u_props (.*);
